/* logic/fp_exception_signalling.sv */
// Floating-point exception signalling with APB registers
`timescale 1ns/1ps
`default_nettype none
module fp_exception_signalling #(
	parameter int         LANES        = 4,
	parameter logic [7:0] DEVNA_VECTOR = 8'h07
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Instruction flow from the core
	input  wire fp_exc_pkg::instr_s    instr,
	input  wire logic                  scalar_err,
	input  wire logic [LANES*fp_exc_pkg::SIMD_NEXC-1:0] simd_lane_flags,
	// Exception delivery and external signals
	output fp_exc_pkg::exc_s           exc,
	output logic                       fpu_error_output,
	output logic                       irq
);
	import fp_exc_pkg::*;

	function automatic logic addr_mapped(input logic [7:0] a);
		if (a == OFS_CTRL)
			return 1'b1;
		else if (a == OFS_SIMD_CSR)
			return 1'b1;
		else if (a == OFS_STATE)
			return 1'b1;
		else if (a == OFS_IRQ_STATUS)
			return 1'b1;
		else if (a == OFS_IRQ_CLEAR)
			return 1'b1;
		else if (a == OFS_IRQ_ENABLE)
			return 1'b1;
		else if (a == OFS_LAST_VEC)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	function automatic logic is_fp(input instr_cls_e c);
		return (c == INSTR_FP_WAIT) || (c == INSTR_NOWAIT) ||
			(c == INSTR_NOWAIT_SAVE) || (c == INSTR_SIMD);
	endfunction

	// State
	logic [1:0]           ctrl_reg, ctrl_next;
	logic                 pend_reg, pend_next;
	logic [SIMD_NEXC-1:0] flags_reg, flags_next;
	logic [SIMD_NEXC-1:0] mask_reg, mask_next;
	logic [1:0]           fpu_error_output_cnt_reg, fpu_error_output_cnt_next;
	logic                 fpu_error_output_reg, fpu_error_output_next;
	exc_s                 exc_reg, exc_next;
	logic [7:0]           last_vec_reg, last_vec_next;
	logic [IRQ_W-1:0]     ist_reg, ist_next;
	logic [IRQ_W-1:0]     ien_reg, ien_next;
	logic [31:0]          rdata_reg, rdata_next;

	// Decode
	logic                 native_mode, task_switched;
	logic                 wr, wr_ctrl, wr_csr;
	logic                 fp_instr, devna_take, num_take, simd_exec;
	logic                 simd_take, fpu_error_output_trig, any_take;
	logic [SIMD_NEXC-1:0] lane_or, lane_unmasked;
	logic [IRQ_W-1:0]     ev;

	simd_lane_merge #(
		.LANES (LANES),
		.NEXC  (SIMD_NEXC)
	) u_merge (
		.lane_flags (simd_lane_flags),
		.mask       (mask_reg),
		.merged     (lane_or),
		.unmasked   (lane_unmasked)
	);

	assign native_mode   = ctrl_reg[CTRL_NATIVE_BIT];
	assign task_switched = ctrl_reg[CTRL_TSW_BIT];
	assign wr      = psel && penable && pwrite;
	assign wr_ctrl = wr && (paddr == OFS_CTRL);
	assign wr_csr  = wr && (paddr == OFS_SIMD_CSR);

	assign fp_instr   = instr.valid && is_fp(instr.cls);
	// Unavailable fault pre-empts the instruction and any numeric error
	assign devna_take = fp_instr && task_switched;
	// Vector 16 only in native mode, only on a waiting FP instruction
	assign num_take = instr.valid && (instr.cls == INSTR_FP_WAIT) &&
		pend_reg && native_mode && !task_switched;
	assign simd_exec = instr.valid && (instr.cls == INSTR_SIMD) &&
		!task_switched;
	// Only this instruction's new unmasked flags can fault
	assign simd_take = simd_exec && (|lane_unmasked);
	// Same trigger point whatever the mode bit says
	assign fpu_error_output_trig = pend_reg && instr.valid && !task_switched &&
		((instr.cls == INSTR_FP_WAIT) ||
		(instr.cls == INSTR_NOWAIT_SAVE));
	assign any_take = devna_take || num_take || simd_take;

	// Control, pending error and SIMD status
	always_comb begin
		ctrl_next  = ctrl_reg;
		pend_next  = pend_reg;
		flags_next = flags_reg;
		mask_next  = mask_reg;
		if (wr_ctrl) begin
			ctrl_next = pwdata[1:0];
		end
		// No-wait instructions leave the error pending
		if (num_take || (wr_ctrl && pwdata[CTRL_ERRCLR_BIT])) begin
			pend_next = 1'b0;
		end
		if (scalar_err) begin
			pend_next = 1'b1;
		end
		// Flags change only by a write or a new occurrence
		if (wr_csr) begin
			flags_next = pwdata[SIMD_NEXC-1:0];
			mask_next  = pwdata[SIMD_MASK_POS +: SIMD_NEXC];
		end
		// Merged lanes set sticky flags; set wins over a write
		if (simd_exec) begin
			flags_next = flags_next | lane_or;
		end
	end

	// Error output pulse stretcher
	always_comb begin
		fpu_error_output_cnt_next = fpu_error_output_cnt_reg;
		if (fpu_error_output_trig) begin
			fpu_error_output_cnt_next = ERR_PULSE_CYC;
		end else if (fpu_error_output_cnt_reg != 2'h0) begin
			fpu_error_output_cnt_next = fpu_error_output_cnt_reg - 2'h1;
		end
		fpu_error_output_next = (fpu_error_output_cnt_next != 2'h0);
	end

	// Exception delivery
	always_comb begin
		exc_next      = '0;
		last_vec_next = last_vec_reg;
		exc_next.valid = any_take;
		if (devna_take) begin
			exc_next.vector = DEVNA_VECTOR;
		end else if (num_take) begin
			exc_next.vector = VEC_NUMERIC;
		end else if (simd_take) begin
			exc_next.vector = VEC_SIMD;
		end
		// Interrupt enable cleared with the delivery itself
		exc_next.if_clear = any_take && instr.interrupt_request_input_gate;
		if (any_take) begin
			last_vec_next = exc_next.vector;
		end
	end

	// Interrupt status, enable and read data
	always_comb begin
		ev = '0;
		ev[IRQ_NUMERIC] = num_take;
		ev[IRQ_SIMD]    = simd_take;
		ev[IRQ_DEVNA]   = devna_take;
		ev[IRQ_ERROUT]  = fpu_error_output_trig;
		ist_next = ist_reg;
		ien_next = ien_reg;
		if (wr && (paddr == OFS_IRQ_CLEAR)) begin
			ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
		end
		ist_next = ist_next | ev;
		if (wr && (paddr == OFS_IRQ_ENABLE)) begin
			ien_next = pwdata[IRQ_W-1:0];
		end
		rdata_next = rdata_reg;
		if (psel && !penable) begin
			rdata_next = 32'h0000_0000;
			if (paddr == OFS_CTRL) begin
				rdata_next[1:0] = ctrl_reg;
			end else if (paddr == OFS_SIMD_CSR) begin
				rdata_next[SIMD_NEXC-1:0] = flags_reg;
				rdata_next[SIMD_MASK_POS +: SIMD_NEXC] = mask_reg;
			end else if (paddr == OFS_STATE) begin
				rdata_next[0] = pend_reg;
				rdata_next[1] = fpu_error_output_reg;
			end else if (paddr == OFS_IRQ_STATUS) begin
				rdata_next[IRQ_W-1:0] = ist_reg;
			end else if (paddr == OFS_IRQ_ENABLE) begin
				rdata_next[IRQ_W-1:0] = ien_reg;
			end else if (paddr == OFS_LAST_VEC) begin
				rdata_next[7:0] = last_vec_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= CTRL_RST;
			pend_reg     <= 1'b0;
			flags_reg    <= SIMD_FLAG_RST;
			mask_reg     <= SIMD_MASK_RST;
			fpu_error_output_cnt_reg <= 2'h0;
			fpu_error_output_reg     <= 1'b0;
			exc_reg      <= '0;
			last_vec_reg <= 8'h00;
			ist_reg      <= '0;
			ien_reg      <= '0;
			rdata_reg    <= 32'h0000_0000;
		end else begin
			ctrl_reg     <= ctrl_next;
			pend_reg     <= pend_next;
			flags_reg    <= flags_next;
			mask_reg     <= mask_next;
			fpu_error_output_cnt_reg <= fpu_error_output_cnt_next;
			fpu_error_output_reg     <= fpu_error_output_next;
			exc_reg      <= exc_next;
			last_vec_reg <= last_vec_next;
			ist_reg      <= ist_next;
			ien_reg      <= ien_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign exc              = exc_reg;
	assign fpu_error_output = fpu_error_output_reg;
	assign irq              = |(ist_reg & ien_reg);
	assign prdata           = rdata_reg;
	assign pready           = 1'b1;
	assign pslverr          = psel && penable && !addr_mapped(paddr);

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_err_pulse;
		fpu_error_output [*2];
	endsequence

	a_devna_first: assert property (devna_take |=>
		exc.valid && exc.vector == DEVNA_VECTOR)
		else $error("unavailable fault not delivered first");
	// A fresh error in the delivery cycle leaves the error pending
	a_native_vec16: assert property (num_take && !scalar_err |=>
		exc.valid && exc.vector == VEC_NUMERIC && !pend_reg)
		else $error("vector 16 not delivered");
	a_nowait_pending: assert property (instr.valid && pend_reg &&
		instr.cls == INSTR_NOWAIT && !wr_ctrl |=>
		pend_reg && !(exc.valid && exc.vector == VEC_NUMERIC))
		else $error("no-wait instruction disturbed pending error");
	a_compat_no_vec: assert property (!native_mode |=>
		!(exc.valid && exc.vector == VEC_NUMERIC))
		else $error("vector 16 raised outside native mode");
	a_err_out_both: assert property (fpu_error_output_trig |=> s_err_pulse)
		else $error("error output pulse too short");
	a_save_pulse: assert property (instr.valid && pend_reg &&
		instr.cls == INSTR_NOWAIT_SAVE && !task_switched |=>
		fpu_error_output)
		else $error("state save did not pulse error output");
	a_simd_fault: assert property (simd_exec &&
		(|(lane_or & ~mask_reg)) |=> exc.valid && exc.vector == VEC_SIMD)
		else $error("unmasked SIMD exception not faulted");
	a_simd_masked: assert property (simd_exec &&
		(lane_or & ~mask_reg) == '0 |=> !exc.valid &&
		((flags_reg & $past(lane_or)) == $past(lane_or)))
		else $error("masked SIMD exception mishandled");
	// Flag already set with its mask clear, nothing new raised
	a_old_flag_quiet: assert property (simd_exec &&
		lane_or == '0 && (|(flags_reg & ~mask_reg)) |=> !exc.valid)
		else $error("old SIMD flag raised a fault");
	a_gate_if_clear: assert property (any_take &&
		instr.interrupt_request_input_gate |=> exc.valid && exc.if_clear)
		else $error("interrupt enable not cleared");
	a_flags_sticky: assert property (!wr_csr && !simd_exec |=>
		flags_reg == $past(flags_reg))
		else $error("sticky flags changed on their own");
endmodule
`default_nettype wire

/* logic/fp_exc_pkg.sv */
// Shared constants and types of the floating-point exception signalling block
`default_nettype none
package fp_exc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_SIMD_CSR   = 8'h04;
	localparam logic [7:0] OFS_STATE      = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] OFS_LAST_VEC   = 8'h18;
	// Control register fields
	localparam int CTRL_NATIVE_BIT = 0;
	localparam int CTRL_TSW_BIT    = 1;
	localparam int CTRL_ERRCLR_BIT = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// SIMD control/status fields: flags low, masks above
	localparam int SIMD_NEXC     = 6;
	localparam int SIMD_MASK_POS = 6;
	localparam logic [5:0] SIMD_FLAG_RST = 6'h00;
	localparam logic [5:0] SIMD_MASK_RST = 6'h3F;
	// Vectors
	localparam logic [7:0] VEC_NUMERIC = 8'h10;
	localparam logic [7:0] VEC_SIMD    = 8'h13;
	// Error output pulse length in cycles
	localparam logic [1:0] ERR_PULSE_CYC = 2'h2;
	// Interrupt status bits
	localparam int IRQ_NUMERIC = 0;
	localparam int IRQ_SIMD    = 1;
	localparam int IRQ_DEVNA   = 2;
	localparam int IRQ_ERROUT  = 3;
	localparam int IRQ_W       = 4;

	typedef enum logic [2:0] {
		INSTR_OTHER,
		INSTR_FP_WAIT,
		INSTR_NOWAIT,
		INSTR_NOWAIT_SAVE,
		INSTR_SIMD
	} instr_cls_e;

	typedef struct packed {
		logic       valid;
		instr_cls_e cls;
		logic       interrupt_request_input_gate;
	} instr_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
		logic       if_clear;
	} exc_s;
endpackage
`default_nettype wire

/* logic/simd_lane_merge.sv */
// OR of SIMD exception flags across lanes and the unmasked subset
`timescale 1ns/1ps
`default_nettype none
module simd_lane_merge #(
	parameter int LANES = 4,
	parameter int NEXC  = 6
) (
	// Per-lane raised flags
	input  wire logic [LANES*NEXC-1:0] lane_flags,
	// Mask bits, one means masked
	input  wire logic [NEXC-1:0]       mask,
	// Merged results
	output logic      [NEXC-1:0]       merged,
	output logic      [NEXC-1:0]       unmasked
);
	logic [NEXC-1:0] partial [LANES+1];

	assign partial[0] = '0;
	generate
		for (genvar i = 0; i < LANES; i++) begin : g_lane
			assign partial[i+1] = partial[i] | lane_flags[i*NEXC +: NEXC];
		end
	endgenerate

	assign merged   = partial[LANES];
	assign unmasked = partial[LANES] & ~mask;
endmodule
`default_nettype wire

/* tb/fpu_irq_router.sv */
// Far-side interrupt controller model for the error output line
`timescale 1ns/1ps
`default_nettype none
module fpu_irq_router (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Error line and routing enable
	input  wire logic fpu_error_output,
	input  wire logic legacy_en,
	// Request towards the core
	output var  logic interrupt_request_input
);
	// Line stays closed while legacy_en is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_request_input <= 1'b0;
		end else begin
			interrupt_request_input <= fpu_error_output & legacy_en;
		end
	end
endmodule
`default_nettype wire

/* tb/fp_exception_signalling_tb.sv */
// Self-checking bench of the floating-point exception signalling block
`timescale 1ns/1ps
`default_nettype none
module fp_exception_signalling_tb;
	import fp_exc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, scalar_err;
	logic        pready, pslverr, fpu_error_output, irq, legacy_en, req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] lane_flags;
	instr_s      instr;
	exc_s        exc;
	int          n_errors, num_checks;
	fp_exception_signalling i_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr(instr), .scalar_err(scalar_err),
		.simd_lane_flags(lane_flags), .exc(exc),
		.fpu_error_output(fpu_error_output), .irq(irq));
	fpu_irq_router i_router (.pclk(pclk), .presetn(presetn),
		.fpu_error_output(fpu_error_output), .legacy_en(legacy_en),
		.interrupt_request_input(req));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdv(logic [7:0] a, logic [31:0] exp);
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, exp);
	endtask
	// Instruction pulse, then exc and error output one cycle later
	task automatic op(instr_cls_e c, logic g, logic [23:0] f,
			logic [9:0] e, logic fe);
		@(posedge pclk);
		instr <= '{valid: 1'b1, cls: c, interrupt_request_input_gate: g};
		lane_flags <= f;
		@(posedge pclk);
		instr <= '0;
		lane_flags <= 24'h000000;
		#1;
		chk({22'h0, exc}, {22'h0, e});
		chk({31'h0, fpu_error_output}, {31'h0, fe});
	endtask
	task automatic fault;
		@(posedge pclk);
		scalar_err <= 1'b1;
		@(posedge pclk);
		scalar_err <= 1'b0;
	endtask
	initial begin
		logic e;
		n_errors = 0;
		num_checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, scalar_err} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lane_flags = 24'h000000;
		instr = '0;
		legacy_en = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdv(OFS_SIMD_CSR, 32'h00000FC0);
		apb(1'b0, 8'h1C, 32'h0, rd, e);
		chk({rd[30:0], e}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		fault();
		op(INSTR_NOWAIT, 1'b0, 24'h0, 10'h000, 1'b0);
		rdv(OFS_STATE, 32'h1);
		op(INSTR_FP_WAIT, 1'b1, 24'h0, {1'b1, VEC_NUMERIC, 1'b1},
			1'b1);
		rdv(OFS_IRQ_STATUS, 32'h9);
		wr(OFS_IRQ_ENABLE, 32'h1);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h1);
		#1;
		chk({31'h0, irq}, 32'h0);
		fault();
		op(INSTR_NOWAIT_SAVE, 1'b0, 24'h0, 10'h000, 1'b1);
		wr(OFS_CTRL, 32'h3);
		op(INSTR_FP_WAIT, 1'b0, 24'h0, {1'b1, 8'h07, 1'b0}, 1'b0);
		wr(OFS_CTRL, 32'h5);
		rdv(OFS_STATE, 32'h0);
		op(INSTR_SIMD, 1'b0, 24'h100000, 10'h000, 1'b0);
		rdv(OFS_SIMD_CSR, 32'h00000FC4);
		wr(OFS_SIMD_CSR, 32'h0);
		op(INSTR_SIMD, 1'b0, 24'h000800, {1'b1, VEC_SIMD, 1'b0},
			1'b0);
		op(INSTR_SIMD, 1'b0, 24'h0, 10'h000, 1'b0);
		rdv(OFS_SIMD_CSR, 32'h00000020);
		rdv(OFS_LAST_VEC, {24'h0, VEC_SIMD});
		chk({31'h0, req}, 32'h0);
		// Compatibility mode: error output routed out, no vector 16
		wr(OFS_CTRL, 32'h0);
		legacy_en <= 1'b1;
		fault();
		op(INSTR_FP_WAIT, 1'b0, 24'h0, 10'h000, 1'b1);
		@(posedge pclk);
		#1;
		chk({31'h0, req}, 32'h1);
		rdv(OFS_STATE, 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
